// ---- pdio_discrete_io.sv ----
// Purpose: Discrete command and status interface to an external controller
// Assumes: Single mclk at 100 MHz, APB slave for software registers
// Notes: Contacts read zero in reset, standing for the unpowered condition
`timescale 1ns/1ns

module pdio_discrete_io
  import pdio_pkg::*;
#(
  parameter int FILT = FILTER_CYC,
  parameter longint SOAK_CYC = SOAK_CYC_DEF
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] custIn,
  output logic [3:0] custOut,
  input wire pdio_plant_t plant,
  output pdio_act_t act,
  output pdio_heat_t heatState,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  // Soak count must fit the soak counter
  if (SOAK_CYC < 1 || SOAK_CYC >= (64'h1 << SOAK_W)) begin : gSoakChk
    $error("pdio_discrete_io: SOAK_CYC out of range");
  end
  // Filter count must fit the filter counter
  if (FILT < 1 || FILT >= (1 << FILTER_W)) begin : gFiltChk
    $error("pdio_discrete_io: FILT out of range");
  end

  // ==========================================================================
  // Input conditioning
  // ==========================================================================
  logic [3:0] cleanIn;
  pdio_req_t req;

  pdio_input_filter #(
    .WIDTH(4),
    .FILT(FILT)
  ) u_pdio_input_filter (
    .mclk(mclk),
    .resetn(resetn),
    .rawIn(custIn),
    .cleanOut(cleanIn)
  );

  assign req = pdio_req_t'(cleanIn);

  // ==========================================================================
  // State
  // ==========================================================================
  pdio_state_t st;
  pdio_state_t next_st;

  logic extCtrl;
  logic wantHeat;
  logic wantSetback;
  logic wantPump;
  logic wrEn;
  logic rdEn;
  logic addrOk;
  logic selCtrl;
  logic selStatus;
  logic selIrqStat;
  logic selIrqMask;
  logic selPanel;
  logic [31:0] rdWord;
  logic [IRQ_W-1:0] irqEvt;
  logic [1:0] next_err;
  logic [1:0] next_run;

  // Takeover only on the primary unit
  assign extCtrl = req.takeover && st.ctrl[CTRL_PRIMARY];

  // Request source: external inputs or panel
  always_comb begin
    if (extCtrl) begin
      wantHeat = req.heat;
      wantSetback = req.setback;
      wantPump = req.pump;
    end else begin
      wantHeat = st.panel[PANEL_HEAT];
      wantSetback = st.panel[PANEL_SETBACK];
      wantPump = st.panel[PANEL_PUMP];
    end
  end

  // ==========================================================================
  // Register decode
  // ==========================================================================
  // Writes land in the access phase, reads are captured in setup
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;

  // Address decode to one-hot register selects
  always_comb begin
    selCtrl = 1'b0;
    selStatus = 1'b0;
    selIrqStat = 1'b0;
    selIrqMask = 1'b0;
    selPanel = 1'b0;
    if (paddr == REG_CTRL) begin
      selCtrl = 1'b1;
    end else if (paddr == REG_STATUS) begin
      selStatus = 1'b1;
    end else if (paddr == REG_IRQ_STAT) begin
      selIrqStat = 1'b1;
    end else if (paddr == REG_IRQ_MASK) begin
      selIrqMask = 1'b1;
    end else if (paddr == REG_PANEL) begin
      selPanel = 1'b1;
    end
  end

  // Unmapped offsets answer with a slave error
  assign addrOk = selCtrl || selStatus || selIrqStat || selIrqMask || selPanel;

  // ==========================================================================
  // Error code and read data
  // ==========================================================================
  // Error code with alarm as highest priority
  always_comb begin
    if (plant.alarm) begin
      next_err = ERR_ALARM;
    end else if (plant.drumEmpty) begin
      next_err = ERR_EMPTY;
    end else if (plant.drumLow) begin
      next_err = ERR_LOW;
    end else begin
      next_err = ERR_NONE;
    end
  end

  // Read data mux for the word captured at the setup edge
  always_comb begin
    rdWord = '0;
    if (selCtrl) begin
      rdWord = {30'h0, st.ctrl};
    end else if (selStatus) begin
      rdWord = {21'h0, st.heat, extCtrl, req.heat, req.setback,
                req.pump, req.takeover, st.errCode, st.runCode};
    end else if (selIrqStat) begin
      rdWord = {28'h0, st.irqStat};
    end else if (selIrqMask) begin
      rdWord = {28'h0, st.irqMask};
    end else if (selPanel) begin
      rdWord = {28'h0, st.panel};
    end
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Next state of everything
  always_comb begin
    next_st = st;
    irqEvt = '0;
    next_run = RUN_OFF;
    // Heat state machine
    case (st.heat)
      PDIO_IDLE: begin
        if (wantHeat) begin
          next_st.heat = PDIO_WARMUP;
        end
      end
      PDIO_WARMUP: begin
        if (!wantHeat) begin
          next_st.heat = PDIO_IDLE;
        end else if (plant.atSetpoint) begin
          next_st.heat = PDIO_SOAK;
          next_st.soakCnt = '0;
        end
      end
      PDIO_SOAK: begin
        if (!wantHeat) begin
          next_st.heat = PDIO_IDLE;
        end else if (!plant.atSetpoint) begin
          next_st.heat = PDIO_WARMUP;
        end else if (st.soakCnt == SOAK_W'(SOAK_CYC - 1)) begin
          next_st.heat = PDIO_ACTIVE;
        end else begin
          next_st.soakCnt = st.soakCnt + 1'b1;
        end
      end
      PDIO_ACTIVE: begin
        if (!wantHeat) begin
          next_st.heat = PDIO_IDLE;
        end else if (!plant.inWindow) begin
          next_st.heat = PDIO_WARMUP;
        end
      end
      default: next_st.heat = PDIO_IDLE;
    endcase
    next_st.ready = (next_st.heat == PDIO_ACTIVE);

    // Pump request, autostart on entering active
    if (next_st.heat != PDIO_ACTIVE) begin
      next_st.pumpReq = 1'b0;
    end else if (extCtrl || !st.ctrl[CTRL_AUTOSTART]) begin
      next_st.pumpReq = wantPump;
    end else if (!st.ready) begin
      next_st.pumpReq = 1'b1;
    end else begin
      next_st.pumpReq = st.pumpReq || wantPump;
    end

    // Run code
    if (next_st.pumpReq && plant.inWindow) begin
      next_run = RUN_PUMP;
    end else if (next_st.heat == PDIO_ACTIVE) begin
      next_run = RUN_ATTEMP;
    end else if (next_st.heat != PDIO_IDLE) begin
      next_run = RUN_HEAT;
    end
    next_st.runCode = next_run;
    next_st.errCode = next_err;

    // Rising-edge events
    irqEvt[IRQ_ALARM] = plant.alarm && (st.errCode != ERR_ALARM);
    irqEvt[IRQ_READY] = next_st.ready && !st.ready;
    irqEvt[IRQ_TAKEOVER] = extCtrl && !st.takeoverSeen;
    irqEvt[IRQ_EMPTY] = plant.drumEmpty && !st.emptySeen;
    next_st.takeoverSeen = extCtrl;
    next_st.emptySeen = plant.drumEmpty;

    // Register writes; set wins over clear
    if (wrEn) begin
      if (paddr == REG_CTRL) begin
        next_st.ctrl = pwdata[1:0];
      end else if (paddr == REG_IRQ_STAT) begin
        next_st.irqStat = st.irqStat & ~pwdata[IRQ_W-1:0];
      end else if (paddr == REG_IRQ_MASK) begin
        next_st.irqMask = pwdata[IRQ_W-1:0];
      end else if (paddr == REG_PANEL && !extCtrl) begin
        next_st.panel = pwdata[3:0];
      end
    end
    next_st.irqStat = next_st.irqStat | irqEvt;

    // Register reads captured in the setup cycle
    next_st.prdata = rdEn ? rdWord : '0;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // State register; reset opens all contacts
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Contacts: bit0/1 run code, bit2/3 error code
  assign custOut = {st.errCode, st.runCode};
  assign heatState = st.heat;

  // Plant commands
  always_comb begin
    act.heatOn = (st.heat != PDIO_IDLE);
    act.setback = wantSetback;
    act.pumpAir = st.pumpReq && st.ready && plant.inWindow;
    act.crossEnable = !extCtrl && st.panel[PANEL_CROSS];
    act.panelLock = extCtrl;
  end

  assign irq = |(st.irqStat & st.irqMask);
  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;

endmodule

// ---- pdio_pkg.sv ----
// Purpose: Shared constants, types and register map for the discrete I/O block
// Assumes: 100 MHz mclk, APB register access
// Notes: All state of the top module is one packed struct declared here
package pdio_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_MHZ = 100;
  localparam int FILTER_US = 10;
  localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
  localparam int FILTER_W = 12;
  localparam int SOAK_MS = 60000;
  localparam longint SOAK_CYC_DEF = longint'(SOAK_MS) * 1000 * CLK_MHZ; // Too big for int
  localparam int SOAK_W = 34;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_PANEL = 8'h10;

  // Control register fields
  localparam int CTRL_AUTOSTART = 0;
  localparam int CTRL_PRIMARY = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // Panel command fields (ignored under external control)
  localparam int PANEL_HEAT = 0;
  localparam int PANEL_SETBACK = 1;
  localparam int PANEL_PUMP = 2;
  localparam int PANEL_CROSS = 3;

  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_READY = 1;
  localparam int IRQ_TAKEOVER = 2;
  localparam int IRQ_EMPTY = 3;

  // Run and error codes on the output contacts
  localparam logic [1:0] RUN_OFF = 2'h0;
  localparam logic [1:0] RUN_HEAT = 2'h1;
  localparam logic [1:0] RUN_ATTEMP = 2'h2;
  localparam logic [1:0] RUN_PUMP = 2'h3;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_LOW = 2'h1;
  localparam logic [1:0] ERR_EMPTY = 2'h2;
  localparam logic [1:0] ERR_ALARM = 2'h3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PDIO_IDLE = 2'h0,
    PDIO_WARMUP = 2'h1,
    PDIO_SOAK = 2'h3,
    PDIO_ACTIVE = 2'h2
  } pdio_heat_t;

  // Customer request inputs after filtering
  typedef struct packed {
    logic takeover;
    logic pump;
    logic setback;
    logic heat;
  } pdio_req_t;

  // Plant status from the zone controllers
  typedef struct packed {
    logic inWindow;
    logic atSetpoint;
    logic drumLow;
    logic drumEmpty;
    logic alarm;
  } pdio_plant_t;

  // Actuator commands to the plant
  typedef struct packed {
    logic heatOn;
    logic setback;
    logic pumpAir;
    logic crossEnable;
    logic panelLock;
  } pdio_act_t;

  // Whole state of the top module
  typedef struct packed {
    pdio_heat_t heat;
    logic [SOAK_W-1:0] soakCnt;
    logic pumpReq;
    logic [1:0] runCode;
    logic [1:0] errCode;
    logic [1:0] ctrl;
    logic [3:0] panel;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [31:0] prdata;
    logic ready;
    logic takeoverSeen;
    logic emptySeen;
  } pdio_state_t;

endpackage

// ---- pdio_input_filter.sv ----
// Purpose: Two-flop synchroniser and consecutive-sample filter per input
// Assumes: Asynchronous level inputs, one clock
// Notes: Output changes only after FILT cycles of a stable new level
`timescale 1ns/1ns
module pdio_input_filter
  import pdio_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter int FILT = FILTER_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] cleanOut
);

  // Filter count must fit the sample counter
  if (FILT < 1 || FILT >= (1 << FILTER_W)) begin : gFiltChk
    $error("pdio_input_filter: FILT out of range");
  end

  // ==========================================================================
  // Per-bit synchroniser and filter
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : gBit
      logic syncA;
      logic syncB;
      logic [FILTER_W-1:0] cnt;
      logic level;
      // Sync chain, then count stable samples
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          syncA <= 1'b0;
          syncB <= 1'b0;
          cnt <= '0;
          level <= 1'b0;
        end else begin
          syncA <= rawIn[gi];
          syncB <= syncA;
          if (syncB == level) begin
            cnt <= '0;
          end else if (cnt == FILTER_W'(FILT - 1)) begin
            cnt <= '0;
            level <= syncB;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
      assign cleanOut[gi] = level;
    end
  endgenerate

endmodule

// ---- pdio_plc_model.sv ----
// Purpose: Behavioural external controller driving the customer inputs
// Assumes: Bench gives wanted levels on plcCmd
// Notes: Pump request held back until the run code shows at temp
`timescale 1ns/1ns
module pdio_plc_model
  import pdio_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] plcCmd,
  input wire logic [3:0] custOut,
  output logic [3:0] custIn
);
  // ==========================================================================
  // Request levels
  // ==========================================================================
  // Inputs open in reset, pump gated on run bit high
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      custIn <= 4'h0;
    end else begin
      custIn <= {plcCmd[3], plcCmd[2] & custOut[1], plcCmd[1:0]};
    end
  end
endmodule

// ---- pdio_discrete_io_monitor.sv ----
// Purpose: Port checker for the discrete I/O block
// Assumes: One clock, async active-low reset
// Notes: Bound to the top module
`timescale 1ns/1ns
module pdio_discrete_io_monitor
  import pdio_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] custOut,
  input wire pdio_plant_t plant,
  input wire pdio_act_t act,
  input wire pdio_heat_t heatState
);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_open_reset: assert property (disable iff (1'b0) !resetn |-> custOut == 4'h0)
    else $error("contacts not open in reset");
  a_err_alarm: assert property (plant.alarm |=> custOut[3:2] == ERR_ALARM)
    else $error("alarm code missing");
  a_err_empty: assert property (!plant.alarm && plant.drumEmpty |=> custOut[3:2] == ERR_EMPTY)
    else $error("empty code missing");
  a_air_window: assert property (act.pumpAir |-> plant.inWindow)
    else $error("pump air outside window");
  a_air_active: assert property (act.pumpAir |-> heatState == PDIO_ACTIVE)
    else $error("pump air before active");
  a_run_idle: assert property (heatState == PDIO_IDLE |-> custOut[1:0] == RUN_OFF)
    else $error("run code not off");
  a_run_warm: assert property (heatState == PDIO_WARMUP |-> custOut[1:0] == RUN_HEAT)
    else $error("run code not heat on");
  a_soak_first: assert property (heatState == PDIO_ACTIVE && $past(heatState) != PDIO_ACTIVE
    |-> $past(heatState) == PDIO_SOAK)
    else $error("active without soak");
  a_warm_first: assert property ($past(heatState) == PDIO_IDLE && heatState != PDIO_IDLE
    |-> heatState == PDIO_WARMUP)
    else $error("idle left without warm-up");
  a_cross_lock: assert property (act.panelLock |-> !act.crossEnable)
    else $error("crossover under external control");
endmodule
bind pdio_discrete_io pdio_discrete_io_monitor u_pdio_discrete_io_monitor (
  .mclk, .resetn, .custOut, .plant, .act, .heatState);

// ---- pdio_discrete_io_tb_top.sv ----
// Purpose: Self-checking bench for the discrete I/O block
// Assumes: Filter 4 cycles, soak 20 cycles
// Notes: Registers reached over APB, plant driven directly
`timescale 1ns/1ns
module pdio_discrete_io_tb_top import pdio_pkg::*;;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] custIn, custOut;
  logic [3:0] plcCmd = 4'h0;
  pdio_plant_t plant = '0;
  pdio_act_t act;
  pdio_heat_t heatState;
  logic irq, pready, pslverr;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic rdErr = 1'b0;
  logic [2:0] pv [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
  logic [1:0] ev [4] = '{ERR_ALARM, ERR_EMPTY, ERR_LOW, ERR_NONE};
  int errCount = 0;
  int checkCount = 0;
  pdio_discrete_io #(.FILT(4), .SOAK_CYC(20)) u_pdio_discrete_io (.mclk(mclk),
    .resetn(resetn), .custIn(custIn), .custOut(custOut), .plant(plant), .act(act),
    .heatState(heatState), .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pdio_plc_model u_pdio_plc_model (.mclk(mclk), .resetn(resetn), .plcCmd(plcCmd),
    .custOut(custOut), .custIn(custIn));
  // Clock
  initial forever #5 mclk = ~mclk;
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task wrapUp;
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errCount++;
      wrapUp();
    end else begin
      rd = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task waitFor(input pdio_heat_t s);
    int n;
    n = 0;
    while (heatState !== s && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (heatState !== s) begin
      errCount++;
      wrapUp();
    end
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    tick(8);
    chk("reset out", 32'(custOut), 32'h0);
    tick(8);
    resetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'(CTRL_RESET));
    chk("no slverr", 32'(rdErr), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("slverr", 32'(rdErr), 32'h1);
    // Local crossover allowed while the panel has control
    apb(1'b1, REG_PANEL, 32'h8);
    tick(1);
    chk("cross local", 32'(act.crossEnable), 32'h1);
    plcCmd <= 4'h8;
    tick(12);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("ext ctrl", 32'(rd[8]), 32'h1);
    chk("lock", 32'(act.panelLock), 32'h1);
    chk("cross", 32'(act.crossEnable), 32'h0);
    apb(1'b1, REG_IRQ_MASK, 32'h4);
    tick(1);
    chk("irq set", 32'(irq), 32'h1);
    apb(1'b1, REG_IRQ_STAT, 32'h4);
    tick(1);
    chk("irq clr", 32'(irq), 32'h0);
    apb(1'b1, REG_PANEL, 32'h1);
    tick(12);
    chk("panel heat", 32'(heatState), 32'(PDIO_IDLE));
    apb(1'b0, REG_PANEL, 32'h0);
    chk("panel kept", rd, 32'h8);
    $display("test takeover done");
    // Short pulse is filtered away
    plcCmd <= 4'h9;
    tick(2);
    plcCmd <= 4'h8;
    tick(12);
    chk("glitch", 32'(heatState), 32'(PDIO_IDLE));
    plcCmd <= 4'h9;
    waitFor(PDIO_WARMUP);
    chk("run warm", 32'(custOut[1:0]), 32'(RUN_HEAT));
    chk("heat on", 32'(act.heatOn), 32'h1);
    plcCmd <= 4'hB;
    tick(12);
    chk("setback", 32'(act.setback), 32'h1);
    plcCmd <= 4'h9;
    tick(12);
    chk("setback off", 32'(act.setback), 32'h0);
    plant.atSetpoint <= 1'b1;
    plant.inWindow <= 1'b1;
    waitFor(PDIO_SOAK);
    waitFor(PDIO_ACTIVE);
    chk("run temp", 32'(custOut[1:0]), 32'(RUN_ATTEMP));
    plcCmd <= 4'hD;
    tick(12);
    chk("air", 32'(act.pumpAir), 32'h1);
    chk("run pump", 32'(custOut[1:0]), 32'(RUN_PUMP));
    plant.inWindow <= 1'b0;
    tick(1);
    chk("air window", 32'(act.pumpAir), 32'h0);
    plcCmd <= 4'h8;
    waitFor(PDIO_IDLE);
    chk("run off", 32'(custOut[1:0]), 32'(RUN_OFF));
    chk("heat off", 32'(act.heatOn), 32'h0);
    $display("test heat done");
    plcCmd <= 4'h0;
    plant.inWindow <= 1'b1;
    tick(12);
    apb(1'b1, REG_CTRL, 32'h3);
    apb(1'b1, REG_PANEL, 32'h1);
    waitFor(PDIO_ACTIVE);
    tick(2);
    chk("autostart", 32'(act.pumpAir), 32'h1);
    apb(1'b1, REG_PANEL, 32'h0);
    plant <= '0;
    $display("test autostart done");
    for (int i = 0; i < 4; i++) begin
      {plant.drumLow, plant.drumEmpty, plant.alarm} <= pv[i];
      tick(3);
      chk("err code", 32'(custOut[3:2]), 32'(ev[i]));
    end
    $display("test errors done");
    // Events latched: alarm, ready and drum empty
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("irq events", rd, 32'hB);
    // Mid-run reset opens the contacts and restores control
    plant.alarm <= 1'b1;
    tick(3);
    chk("alarm out", 32'(custOut[3:2]), 32'(ERR_ALARM));
    resetn <= 1'b0;
    plant <= '0;
    tick(2);
    chk("reset open", 32'(custOut), 32'h0);
    resetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl again", rd, 32'(CTRL_RESET));
    $display("test reset done");
    wrapUp();
  end
endmodule
